// >>> edb_pkg.sv
// Package for the endpoint descriptor block: register map, field layout and buffer constants.
// Assumes one system clock domain; shared by the descriptor map module and its tests.
package edb_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] OUT_EP0_COUNT_ADDR = 16'hF004;
	localparam logic [3:0] EDB_PREFIX = 4'hF;
	localparam logic [4:0] EDB_ZERO_BITS = 5'h00;
	localparam logic [2:0] EP_FIRST = 3'h1;
	localparam logic [2:0] EP_LAST = 3'h4;
	localparam logic DIR_IN = 1'b0;
	localparam logic DIR_OUT = 1'b1;
	localparam logic [2:0] ENT_CONFIG = 3'h0;
	localparam logic [2:0] ENT_X_BASE = 3'h1;
	localparam logic [2:0] ENT_X_CNT_LO = 3'h2;
	localparam logic [2:0] ENT_X_CNT_HI = 3'h3;
	localparam logic [2:0] ENT_XY_SIZE = 3'h4;
	localparam logic [2:0] ENT_Y_BASE = 3'h5;
	localparam logic [2:0] ENT_Y_CNT_LO = 3'h6;
	localparam logic [2:0] ENT_Y_CNT_HI = 3'h7;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int CNT_FLAG_BIT = 7;
	localparam int DOUBLE_BUFFER_ENABLE_BIT = 4;
	localparam logic [6:0] EP0_MAX_COUNT = 7'h40;
	localparam logic [7:0] ENTRY_RESET = 8'h00;
	localparam logic [7:0] EP0_COUNT_RESET = 8'h00;

	// ------------------------------------------------------------
	// Packet RAM placement
	// ------------------------------------------------------------
	localparam logic [3:0] BUF_PREFIX = 4'hE;
	localparam logic [3:0] BUF_ALIGN_ZERO = 4'h0;
	localparam logic [15:0] EP0_OUT_BUF_START = 16'hE000;
	localparam logic [15:0] EP0_IN_BUF_START = 16'hE040;
	localparam logic [15:0] FREE_SPACE_START = 16'hE080;
	localparam logic [15:0] BUFFER_SPACE_TOP = 16'hEFFF;
	localparam logic [15:0] MAX_PKT_HIGH_SPEED = 16'h0200;
	localparam logic [15:0] MAX_PKT_FULL_SPEED = 16'h0040;

endpackage : edb_pkg

// >>> usb_endpoint_descriptor_map.sv
// Endpoint descriptor register bank with endpoint-0 OUT byte count and buffer address forming.
// Assumes the firmware bus and the protocol engine run on clk; host and firmware keep their part.
`timescale 1ns/1ps
module usb_endpoint_descriptor_map
	import edb_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	input wire logic ep0_out_done,
	input wire logic [10:0] ep0_out_len,
	output logic ep0_out_ack,
	output logic ep0_out_nak,
	output logic ep0_out_notify,
	output logic ep0_out_store_en,
	output logic [15:0] ep0_out_buf_addr,
	output logic [15:0] ep0_in_buf_addr,
	input wire logic [2:0] xfer_ep,
	input wire logic xfer_dir,
	input wire logic data_toggle_state,
	input wire logic high_speed,
	output logic [15:0] xfer_buf_addr,
	output logic xfer_use_y,
	output logic [15:0] xfer_max_pkt,
	output logic xfer_ep_valid
);
	import edb_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] edb_mem [0:1][1:4][0:7];
	logic [7:0] out_ep0_byte_count;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic ep_in_range(input logic [2:0] ep);
		ep_in_range = (ep >= EP_FIRST) && (ep <= EP_LAST);
	endfunction : ep_in_range

	// Descriptor window decode and entry selection.
	wire logic [2:0] acc_ep = reg_addr[6:4];
	wire logic acc_dir = reg_addr[3];
	wire logic [2:0] acc_ent = reg_addr[2:0];
	wire logic edb_hit = (reg_addr[15:12] == EDB_PREFIX) && (reg_addr[11:7] == EDB_ZERO_BITS)
		&& ep_in_range(acc_ep);
	wire logic cnt_hit = (reg_addr == OUT_EP0_COUNT_ADDR);
	assign reg_hit = edb_hit || cnt_hit;

	// ------------------------------------------------------------
	// Descriptor entries
	// ------------------------------------------------------------
	// Each entry is plain firmware storage; reset clears them, leaving double buffering off.
	generate
		for (genvar d = 0; d < 2; d++)
		begin : g_dir
			for (genvar e = 1; e <= 4; e++)
			begin : g_ep
				for (genvar k = 0; k < 8; k++)
				begin : g_ent
					always_ff @(posedge clk or posedge sys_rst)
					begin
						if (sys_rst)
							edb_mem[d][e][k] <= ENTRY_RESET;
						else if (reg_wr && edb_hit && acc_dir == 1'(d) && acc_ep == 3'(e)
							&& acc_ent == 3'(k))
							edb_mem[d][e][k] <= reg_wdata;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Endpoint-0 OUT count and handshake flag
	// ------------------------------------------------------------
	// Oversize packets are dropped silently; legal packets land only while the flag is clear.
	wire logic ep0_flag = out_ep0_byte_count[CNT_FLAG_BIT];
	wire logic ep0_illegal = ep0_out_done && (ep0_out_len > {4'h0, EP0_MAX_COUNT});
	wire logic ep0_accept = ep0_out_done && !ep0_illegal && !ep0_flag;
	wire logic fw_flag_wr = reg_wr && cnt_hit;
	assign ep0_out_ack = ep0_accept;
	assign ep0_out_nak = ep0_out_done && !ep0_illegal && ep0_flag;
	assign ep0_out_notify = ep0_accept;
	assign ep0_out_store_en = ep0_accept;

	// Hardware setting the flag wins over a firmware clear in the same cycle.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			out_ep0_byte_count <= EP0_COUNT_RESET;
		else if (ep0_accept)
			out_ep0_byte_count <= {1'b1, ep0_out_len[6:0]};
		else if (fw_flag_wr)
			out_ep0_byte_count[CNT_FLAG_BIT] <= reg_wdata[CNT_FLAG_BIT];
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Out-of-range endpoints fold onto endpoint 1 so the array is never indexed out of bounds.
	wire logic [2:0] acc_ep_idx = ep_in_range(acc_ep) ? acc_ep : EP_FIRST;
	wire logic [7:0] edb_rd = edb_mem[acc_dir][acc_ep_idx][acc_ent];

	// Read data is registered on a read strobe; unmapped reads return zero.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			reg_rdata <= ENTRY_RESET;
		else if (reg_rd)
			reg_rdata <= cnt_hit ? out_ep0_byte_count : (edb_hit ? edb_rd : ENTRY_RESET);
	end

	// ------------------------------------------------------------
	// Buffer address forming
	// ------------------------------------------------------------
	function automatic logic [15:0] buf_addr(input logic [7:0] base);
		buf_addr = {BUF_PREFIX, base, BUF_ALIGN_ZERO};
	endfunction : buf_addr

	// Transfer lookup: pick X or Y by toggle only when double buffering is on.
	wire logic [2:0] lk_ep = ep_in_range(xfer_ep) ? xfer_ep : EP_FIRST;
	wire logic [7:0] lk_cfg = edb_mem[xfer_dir][lk_ep][ENT_CONFIG];
	wire logic lk_double_buffer_enable = lk_cfg[DOUBLE_BUFFER_ENABLE_BIT];
	wire logic lk_use_y = lk_double_buffer_enable && data_toggle_state;
	wire logic [7:0] lk_base = lk_use_y ? edb_mem[xfer_dir][lk_ep][ENT_Y_BASE]
		: edb_mem[xfer_dir][lk_ep][ENT_X_BASE];

	// Data outputs are registered to give one cycle of lookup latency.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			xfer_buf_addr <= EP0_OUT_BUF_START;
			xfer_use_y <= 1'b0;
			xfer_max_pkt <= MAX_PKT_FULL_SPEED;
			xfer_ep_valid <= 1'b0;
			ep0_out_buf_addr <= EP0_OUT_BUF_START;
			ep0_in_buf_addr <= EP0_IN_BUF_START;
		end
		else
		begin
			xfer_buf_addr <= buf_addr(lk_base);
			xfer_use_y <= lk_use_y;
			xfer_max_pkt <= high_speed ? MAX_PKT_HIGH_SPEED : MAX_PKT_FULL_SPEED;
			xfer_ep_valid <= ep_in_range(xfer_ep);
			ep0_out_buf_addr <= EP0_OUT_BUF_START;
			ep0_in_buf_addr <= EP0_IN_BUF_START;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Packet classes seen when an endpoint-0 OUT packet ends.
	sequence s_legal_pkt;
		ep0_out_done && ep0_out_len <= 11'h040 && !ep0_flag;
	endsequence

	sequence s_oversize_pkt;
		ep0_out_done && ep0_out_len > 11'h040;
	endsequence

	// Firmware writes zero to the flag while no packet is taken in the same cycle.
	sequence s_fw_clear;
		reg_wr && cnt_hit && !reg_wdata[CNT_FLAG_BIT] && !ep0_accept;
	endsequence

	// A descriptor write, one idle bus cycle, then a read of the same entry.
	sequence s_entry_wr;
		reg_wr && edb_hit;
	endsequence

	sequence s_same_rd;
		!reg_wr ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2);
	endsequence

	// ------------------------------------------------------------
	// Checks: endpoint-0 count and flag
	// ------------------------------------------------------------
	// The count field never leaves the range 0 to 64.
	count_range_a: assert property (@(posedge clk) disable iff (sys_rst)
		out_ep0_byte_count[6:0] <= 7'h40)
		else $error("Endpoint-0 OUT count above 64.");

	// Only a packet end may move the count; firmware writes leave it alone.
	count_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!ep0_out_done |=> $stable(out_ep0_byte_count[6:0]))
		else $error("Endpoint-0 OUT count moved without a packet.");

	// An oversize packet gets no answer at all.
	illegal_silent_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_oversize_pkt |-> !ep0_out_ack && !ep0_out_nak && !ep0_out_notify)
		else $error("Oversize packet answered.");

	// An oversize packet leaves the count of the previous packet in place.
	illegal_keeps_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_oversize_pkt |=> $stable(out_ep0_byte_count[6:0]))
		else $error("Oversize packet changed count.");

	// A legal packet into a full buffer is refused with a NAK.
	flag_nak_a: assert property (@(posedge clk) disable iff (sys_rst)
		(ep0_out_done && ep0_flag && ep0_out_len <= 11'h040) |-> ep0_out_nak && !ep0_out_ack)
		else $error("Full buffer not NAKed.");

	// The host never sees both answers for one packet.
	answer_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
		!(ep0_out_ack && ep0_out_nak))
		else $error("Packet answered with both ACK and NAK.");

	// A legal packet into an empty buffer is acknowledged, stored and announced.
	legal_answer_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_legal_pkt |-> ep0_out_ack && ep0_out_store_en && ep0_out_notify && !ep0_out_nak)
		else $error("Legal packet not taken.");

	// The same packet leaves its length and a set flag behind.
	accept_sets_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_legal_pkt |=> ep0_flag && out_ep0_byte_count[6:0] == $past(ep0_out_len[6:0]))
		else $error("Legal packet not recorded.");

	// A firmware clear empties the buffer for the next packet.
	flag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_fw_clear |=> !ep0_flag)
		else $error("Firmware clear of the flag lost.");

	// ------------------------------------------------------------
	// Checks: register decode
	// ------------------------------------------------------------
	// Addresses outside the descriptor window never hit.
	hit_prefix_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_addr[15:12] != 4'hF || reg_addr[11:7] != 5'h00) |-> !reg_hit)
		else $error("Address outside the window decoded.");

	// Endpoints above 4 have no descriptor block.
	hit_range_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_addr[15:7] == 9'h1E0 && reg_addr[6:4] > 3'h4) |-> !reg_hit)
		else $error("Missing endpoint decoded.");

	// A written entry reads back unchanged.
	entry_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
		s_entry_wr ##1 s_same_rd |=> reg_rdata == $past(reg_wdata, 3))
		else $error("Descriptor entry read back wrong.");

	// ------------------------------------------------------------
	// Checks: buffer placement and lookup
	// ------------------------------------------------------------
	// The endpoint-0 IN buffer sits right above the 64-byte OUT buffer.
	buf_place_a: assert property (@(posedge clk) disable iff (sys_rst)
		ep0_in_buf_addr == 16'hE040)
		else $error("Endpoint-0 IN buffer misplaced.");

	// The endpoint-0 OUT buffer always starts at the bottom of the packet RAM.
	out_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		ep0_out_buf_addr == 16'hE000)
		else $error("Endpoint-0 OUT buffer misplaced.");

	// Both endpoint-0 buffers end below the space left to other endpoints.
	ep0_below_free_a: assert property (@(posedge clk) disable iff (sys_rst)
		ep0_out_buf_addr < ep0_in_buf_addr && ep0_in_buf_addr + 16'h0040 <= 16'hE080)
		else $error("Endpoint-0 buffers reach into free space.");

	// Formed buffer addresses stay inside the buffer space.
	buf_space_a: assert property (@(posedge clk) disable iff (sys_rst)
		xfer_buf_addr[15:12] == 4'hE && xfer_buf_addr <= BUFFER_SPACE_TOP)
		else $error("Buffer address outside buffer space.");

	// Lookups mark endpoints outside 1 to 4 as invalid.
	lookup_valid_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> xfer_ep_valid == ($past(xfer_ep) >= 3'h1 && $past(xfer_ep) <= 3'h4))
		else $error("Lookup endpoint validity wrong.");

	// Without double buffering the Y buffer is never chosen.
	single_buf_a: assert property (@(posedge clk) disable iff (sys_rst)
		!lk_double_buffer_enable |=> !xfer_use_y)
		else $error("Y buffer used without double buffering.");

	// With double buffering the toggle state picks the buffer.
	toggle_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
		lk_double_buffer_enable |=> xfer_use_y == $past(data_toggle_state))
		else $error("Toggle did not pick buffer.");

	// The stored base lands in bits 11 to 4 with four zero bits below.
	addr_align_a: assert property (@(posedge clk) disable iff (sys_rst)
		xfer_buf_addr[3:0] == 4'h0 && xfer_buf_addr[11:4] == $past(lk_base))
		else $error("Buffer address badly formed.");

	// The packet size limit follows the bus speed.
	max_pkt_a: assert property (@(posedge clk) disable iff (sys_rst)
		1'b1 |=> xfer_max_pkt == ($past(high_speed) ? 16'h0200 : 16'h0040))
		else $error("Wrong packet size limit.");

endmodule : usb_endpoint_descriptor_map

// >>> host_model.sv
// Model of the host side: ends endpoint-0 OUT packets with a given length.
// Assumes the bench calls its tasks from one process, on clk.
`timescale 1ns/1ps
module host_model
(
	input wire logic clk,
	output logic done,
	output logic [10:0] len
);
	// Idle bus: no packet end, length not held at any real value.
	initial
	begin
		done = 1'b0;
		len = 11'h7ff;
	end

	// Raise the packet end pulse with its length for one cycle.
	task send(input logic [10:0] n);
		@(posedge clk);
		done <= 1'b1;
		len <= n;
	endtask : send

	// Release the pulse; the length bus flips so a stale value cannot pass.
	task rel;
		@(posedge clk);
		done <= 1'b0;
		len <= ~len;
	endtask : rel
endmodule : host_model

// >>> usb_endpoint_descriptor_map_test.sv
// Self-checking bench for the endpoint descriptor map.
// Assumes edb_pkg and host_model are compiled first.
`timescale 1ns/1ps
module usb_endpoint_descriptor_map_test;
	import edb_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [2:0] xfer_ep = 3'h1;
	logic xfer_dir = 1'b0;
	logic tog = 1'b0;
	logic hs = 1'b0;
	logic [7:0] rdata;
	logic hit, ack, nak, ntf, st, uy, ev, done;
	logic [15:0] oba, iba, xba, mp;
	logic [10:0] len;
	int error_cnt = 0;
	int checked = 0;

	usb_endpoint_descriptor_map i_usb_endpoint_descriptor_map (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(rdata), .reg_hit(hit), .ep0_out_done(done), .ep0_out_len(len),
		.ep0_out_ack(ack), .ep0_out_nak(nak), .ep0_out_notify(ntf), .ep0_out_store_en(st),
		.ep0_out_buf_addr(oba), .ep0_in_buf_addr(iba), .xfer_ep(xfer_ep), .xfer_dir(xfer_dir),
		.data_toggle_state(tog), .high_speed(hs), .xfer_buf_addr(xba), .xfer_use_y(uy),
		.xfer_max_pkt(mp), .xfer_ep_valid(ev));
	host_model i_host_model (.clk(clk), .done(done), .len(len));

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	// Compare helpers count every check and report a mismatch at once.
	task chk_v(input string n, input logic [15:0] e, input logic [15:0] s);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk_v
	task chk_f(input string n, input logic e, input logic s);
		chk_v(n, {15'h0000, e}, {15'h0000, s});
	endtask : chk_f

	// Verdict and end of run.
	task test_done;
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// Register write and read cycles of the firmware bus.
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [15:0] a, input logic [7:0] e, input logic h);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		#1 chk_f("reg_hit", h, hit);
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk_v("reg_rdata", {8'h00, e}, {8'h00, rdata});
	endtask : rd

	// One endpoint-0 packet end; store and notify follow acknowledge.
	task pkt(input logic [10:0] n, input logic a, input logic k);
		i_host_model.send(n);
		#1 chk_f("ack", a, ack);
		chk_f("nak", k, nak);
		chk_f("notify", a, ntf);
		chk_f("store", a, st);
		i_host_model.rel();
	endtask : pkt

	// Buffer lookup, answered one cycle after the inputs.
	task lk(input logic [2:0] e, input logic d, input logic t, input logic h,
		input logic [15:0] a, input logic y, input logic [15:0] m);
		@(posedge clk);
		xfer_ep <= e;
		xfer_dir <= d;
		tog <= t;
		hs <= h;
		@(posedge clk);
		#1 chk_v("buf addr", a, xba);
		chk_f("use y", y, uy);
		chk_v("max pkt", m, mp);
		chk_f("ep valid", (e >= 3'h1 && e <= 3'h4), ev);
	endtask : lk

	// Entry value unique to endpoint, direction and entry.
	function automatic logic [7:0] val(input int e, input int d, input int k);
		return {e[1:0], d[0], 2'b00, k[2:0]};
	endfunction : val

	// Main sequence.
	initial
	begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(16'hF004, 8'h00, 1'b1);
		rd(16'hF010, 8'h00, 1'b1);
		chk_v("out buf", 16'hE000, oba);
		chk_v("in buf", 16'hE040, iba);
		for (int p = 0; p < 2; p++)
			for (int e = 1; e <= 4; e++)
				for (int d = 0; d < 2; d++)
					for (int k = 1; k < 7; k++)
						if (k != 3)
							if (p == 0)
								wr({4'hF, 5'h00, e[2:0], d[0], k[2:0]}, val(e, d, k));
							else
								rd({4'hF, 5'h00, e[2:0], d[0], k[2:0]}, val(e, d, k), 1'b1);
		wr(16'hF051, 8'hFF);
		rd(16'hF051, 8'h00, 1'b0);
		rd(16'hF089, 8'h00, 1'b0);
		wr(16'hF004, 8'h7F);
		rd(16'hF004, 8'h00, 1'b1);
		pkt(11'h00A, 1'b1, 1'b0);
		rd(16'hF004, 8'h8A, 1'b1);
		pkt(11'h014, 1'b0, 1'b1);
		rd(16'hF004, 8'h8A, 1'b1);
		wr(16'hF004, 8'h00);
		pkt(11'h040, 1'b1, 1'b0);
		rd(16'hF004, 8'hC0, 1'b1);
		wr(16'hF004, 8'h00);
		pkt(11'h041, 1'b0, 1'b0);
		pkt(11'h7FF, 1'b0, 1'b0);
		rd(16'hF004, 8'h40, 1'b1);
		wr(16'hF028, 8'h10);
		rd(16'hF028, 8'h10, 1'b1);
		lk(3'h2, 1'b1, 1'b1, 1'b0, 16'hEA50, 1'b1, 16'h0040);
		lk(3'h2, 1'b1, 1'b0, 1'b1, 16'hEA10, 1'b0, 16'h0200);
		lk(3'h2, 1'b0, 1'b1, 1'b0, 16'hE810, 1'b0, 16'h0040);
		lk(3'h5, 1'b1, 1'b1, 1'b0, 16'hE610, 1'b0, 16'h0040);
		test_done();
	end

	// Watchdog: the sequence needs well under 2000 cycles.
	initial
	begin
		#50000;
		error_cnt++;
		test_done();
	end
endmodule : usb_endpoint_descriptor_map_test
